// ### rtl/arpct_timer.v
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "arpct_defines.vh"

module arpct_timer (
    // clock, reset, enable
    input  wire        CLOCK_IN,
    input  wire        RESET_IN,
    input  wire        CE_IN,
    // system state and pins
    input  wire        HALT_IN,
    input  wire        EXT_CLK_IN,
    input  wire [1:0]  CAPTURE_INPUT_PIN_IN,
    output reg  [3:0]  PULSE_OUTPUT_PIN_OUT,
    output reg  [3:0]  PULSE_OUTPUT_OE_OUT,
    // interrupt requests
    output reg         WRAP_IRQ_OUT,
    output reg  [1:0]  CAPTURE_IRQ_OUT,
    output reg         WAKEUP_OUT,
    // axi4-lite write
    input  wire [11:0] AXI_AWADDR_IN,
    input  wire        AXI_AWVALID_IN,
    output reg         AXI_AWREADY_OUT,
    input  wire [31:0] AXI_WDATA_IN,
    input  wire [3:0]  AXI_WSTRB_IN,
    input  wire        AXI_WVALID_IN,
    output reg         AXI_WREADY_OUT,
    output reg  [1:0]  AXI_BRESP_OUT,
    output reg         AXI_BVALID_OUT,
    input  wire        AXI_BREADY_IN,
    // axi4-lite read
    input  wire [11:0] AXI_ARADDR_IN,
    input  wire        AXI_ARVALID_IN,
    output reg         AXI_ARREADY_OUT,
    output reg  [31:0] AXI_RDATA_OUT,
    output reg  [1:0]  AXI_RRESP_OUT,
    output reg         AXI_RVALID_OUT,
    input  wire        AXI_RREADY_IN
);

    // ======================================================================
    // functions
    function hit;
        input [11:0] addr;
        input [7:0]  idx;
        begin
            hit = (addr[11:10] == 2'h0) && (addr[9:2] == idx);
        end
    endfunction

    function mapped;
        input [11:0] addr;
        begin
            mapped = (addr[11:10] == 2'h0) && (addr[1:0] == 2'h0) &&
                     (addr[9:2] >= `ARPCT_IDX_DUTY3) && (addr[9:2] <= `ARPCT_IDX_CAP2);
        end
    endfunction

    // ======================================================================
    // state
    reg  [7:0] tcsr_q;
    reg        wrap_q;
    reg  [7:0] reload_q;
    reg  [7:0] pctl_q;
    reg  [5:2] ccsr_q;
    reg  [1:0] cflag_q;
    reg  [7:0] cap_q [0:1];
    reg  [7:0] duty_q [0:3];
    reg  [7:0] shadow_q [0:3];
    reg  [7:0] cnt_q;
    reg  [6:0] presc_q;
    reg  [7:0] rdata_d;
    reg        rd_ok_d;

    wire       ext_rise;
    wire [1:0] cap_rise;
    wire [1:0] cap_fall;
    wire [1:0] cap_edge;

    // ======================================================================
    // pin synchronisers
    arpct_edge_sync u_ext_sync (
        .clk  (CLOCK_IN),
        .rst  (RESET_IN),
        .ce   (CE_IN),
        .pin  (EXT_CLK_IN),
        .rise (ext_rise),
        .fall ()
    );

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_cap_sync
            arpct_edge_sync u_cap_sync (
                .clk  (CLOCK_IN),
                .rst  (RESET_IN),
                .ce   (CE_IN),
                .pin  (CAPTURE_INPUT_PIN_IN[gi]),
                .rise (cap_rise[gi]),
                .fall (cap_fall[gi])
            );
            // edge select per channel
            assign cap_edge[gi] = ccsr_q[`ARPCT_CCSR_EDGE_L + gi] ?
                                  cap_rise[gi] : cap_fall[gi];
        end
    endgenerate

    // ======================================================================
    // bus handshake decode
    wire wr_take = AXI_AWREADY_OUT;
    wire rd_take = AXI_ARREADY_OUT;
    // cpu is stopped in halt, so writes there are dropped
    wire wr_en   = CE_IN & wr_take & ~HALT_IN & AXI_WSTRB_IN[0];
    wire rd_en   = CE_IN & rd_take;
    wire [7:0] wd = AXI_WDATA_IN[7:0];

    wire wr_cnt    = wr_en & hit(AXI_AWADDR_IN, `ARPCT_IDX_CNT);
    wire wr_tcsr   = wr_en & hit(AXI_AWADDR_IN, `ARPCT_IDX_TCSR);
    wire force_rl  = wr_tcsr & wd[`ARPCT_TCSR_FRL];
    wire rd_tcsr   = rd_en & hit(AXI_ARADDR_IN, `ARPCT_IDX_TCSR);
    wire [1:0] rd_cap;
    assign rd_cap[0] = rd_en & hit(AXI_ARADDR_IN, `ARPCT_IDX_CAP1);
    assign rd_cap[1] = rd_en & hit(AXI_ARADDR_IN, `ARPCT_IDX_CAP2);

    // ======================================================================
    // prescaler and counter tick
    wire       use_ext = tcsr_q[`ARPCT_TCSR_EXT];
    wire       in_tick = use_ext ? ext_rise : 1'b1;
    // cpu clock stops in halt; only the external source keeps counting
    wire       run     = CE_IN & tcsr_q[`ARPCT_TCSR_RUN] &
                         (~HALT_IN | use_ext);
    wire [6:0] tap     = ~(7'h7F << tcsr_q[`ARPCT_TCSR_TAP_H:`ARPCT_TCSR_TAP_L]);
    wire       cnt_tick = run & in_tick & ((presc_q & tap) == tap);
    wire       wrap_ev = cnt_tick & (cnt_q == `ARPCT_CNT_TOP) & ~wr_cnt & ~force_rl;

    always @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            presc_q <= 7'h00;
            cnt_q   <= `ARPCT_RST8;
        end else if (CE_IN) begin
            if (wr_cnt) begin
                cnt_q   <= wd;
                presc_q <= 7'h00;
            end else if (force_rl) begin
                cnt_q   <= reload_q;
                presc_q <= 7'h00;
            end else if (run & in_tick) begin
                presc_q <= presc_q + 7'h01;
                if (cnt_tick) begin
                    // reload leaves the prescaler alone, 256-reload counter ticks per wrap
                    cnt_q <= wrap_ev ? reload_q : cnt_q + 8'h01;
                end
            end
        end
    end

    // ======================================================================
    // control registers
    integer k, kw, kc, ko;
    always @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            tcsr_q   <= `ARPCT_RST8;
            reload_q <= `ARPCT_RST8;
            pctl_q   <= `ARPCT_RST8;
            ccsr_q   <= 4'h0;
            for (k = 0; k < 4; k = k + 1) begin
                duty_q[k] <= `ARPCT_RST8;
            end
        end else if (wr_en) begin
            if (wr_tcsr)
                tcsr_q <= wd & `ARPCT_TCSR_WMASK;
            if (hit(AXI_AWADDR_IN, `ARPCT_IDX_RELOAD))
                reload_q <= wd;
            if (hit(AXI_AWADDR_IN, `ARPCT_IDX_PCTL))
                pctl_q <= wd;
            if (hit(AXI_AWADDR_IN, `ARPCT_IDX_CCSR))
                ccsr_q <= wd[5:2];
            for (k = 0; k < 4; k = k + 1) begin
                if (hit(AXI_AWADDR_IN, `ARPCT_IDX_DUTY0 - k[7:0]))
                    duty_q[k] <= wd;
            end
        end
    end

    // ======================================================================
    // wrap flag, compare shadows
    always @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            wrap_q <= 1'b0;
            for (kw = 0; kw < 4; kw = kw + 1) begin
                shadow_q[kw] <= `ARPCT_RST8;
            end
        end else if (CE_IN) begin
            // set wins over a read that clears in the same cycle
            if (wrap_ev)
                wrap_q <= 1'b1;
            else if (rd_tcsr)
                wrap_q <= 1'b0;
            if (wrap_ev) begin
                for (kw = 0; kw < 4; kw = kw + 1) begin
                    shadow_q[kw] <= duty_q[kw];
                end
            end
        end
    end

    // ======================================================================
    // input capture
    always @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            cflag_q  <= 2'h0;
            cap_q[0] <= `ARPCT_RST8;
            cap_q[1] <= `ARPCT_RST8;
        end else if (CE_IN) begin
            for (kc = 0; kc < 2; kc = kc + 1) begin
                // a read clearing the flag lets a same-cycle edge through
                if (cap_edge[kc] & (~cflag_q[kc] | rd_cap[kc])) begin
                    cap_q[kc]   <= cnt_q;
                    cflag_q[kc] <= 1'b1;
                end else if (rd_cap[kc]) begin
                    cflag_q[kc] <= 1'b0;
                end
            end
        end
    end

    // ======================================================================
    // outputs
    always @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            PULSE_OUTPUT_PIN_OUT <= 4'h0;
            PULSE_OUTPUT_OE_OUT  <= 4'h0;
            WRAP_IRQ_OUT         <= 1'b0;
            CAPTURE_IRQ_OUT      <= 2'h0;
            WAKEUP_OUT           <= 1'b0;
        end else if (CE_IN) begin
            PULSE_OUTPUT_OE_OUT <= pctl_q[`ARPCT_PCTL_OE_H:`ARPCT_PCTL_OE_L];
            // pulse generation stops in halt, levels are held
            if (~HALT_IN) begin
                for (ko = 0; ko < 4; ko = ko + 1) begin
                    PULSE_OUTPUT_PIN_OUT[ko] <= pctl_q[`ARPCT_PCTL_OE_L + ko] &
                        ((cnt_q <= shadow_q[ko]) ^ pctl_q[`ARPCT_PCTL_POL_L + ko]);
                end
            end
            WRAP_IRQ_OUT    <= wrap_q & tcsr_q[`ARPCT_TCSR_WIE];
            CAPTURE_IRQ_OUT <= cflag_q & ccsr_q[`ARPCT_CCSR_IE_H:`ARPCT_CCSR_IE_L];
            WAKEUP_OUT      <= HALT_IN &
                ((wrap_q & tcsr_q[`ARPCT_TCSR_WIE]) |
                 (|(cflag_q & ccsr_q[`ARPCT_CCSR_IE_H:`ARPCT_CCSR_IE_L])));
        end
    end

    // ======================================================================
    // read mux
    always @* begin
        rdata_d = `ARPCT_RST8;
        rd_ok_d = mapped(AXI_ARADDR_IN);
        case (AXI_ARADDR_IN[9:2])
            `ARPCT_IDX_DUTY3:  rdata_d = duty_q[3];
            `ARPCT_IDX_DUTY2:  rdata_d = duty_q[2];
            `ARPCT_IDX_DUTY1:  rdata_d = duty_q[1];
            `ARPCT_IDX_DUTY0:  rdata_d = duty_q[0];
            `ARPCT_IDX_PCTL:   rdata_d = pctl_q;
            `ARPCT_IDX_TCSR:   rdata_d = {tcsr_q[7:1], wrap_q};
            `ARPCT_IDX_CNT:    rdata_d = cnt_q;
            `ARPCT_IDX_RELOAD: rdata_d = reload_q;
            `ARPCT_IDX_CCSR:   rdata_d = {2'h0, ccsr_q, cflag_q};
            `ARPCT_IDX_CAP1:   rdata_d = cap_q[0];
            `ARPCT_IDX_CAP2:   rdata_d = cap_q[1];
            default:           rdata_d = `ARPCT_RST8;
        endcase
        if (!rd_ok_d)
            rdata_d = `ARPCT_RST8;
    end

    // ======================================================================
    // axi4-lite slave: one write and one read in flight
    always @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            AXI_AWREADY_OUT <= 1'b0;
            AXI_WREADY_OUT  <= 1'b0;
            AXI_BVALID_OUT  <= 1'b0;
            AXI_BRESP_OUT   <= `ARPCT_RESP_OKAY;
            AXI_ARREADY_OUT <= 1'b0;
            AXI_RVALID_OUT  <= 1'b0;
            AXI_RRESP_OUT   <= `ARPCT_RESP_OKAY;
            AXI_RDATA_OUT   <= 32'h00000000;
        end else if (CE_IN) begin
            // address and data are taken together in one cycle
            AXI_AWREADY_OUT <= AXI_AWVALID_IN & AXI_WVALID_IN &
                               ~AXI_AWREADY_OUT & ~AXI_BVALID_OUT;
            AXI_WREADY_OUT  <= AXI_AWVALID_IN & AXI_WVALID_IN &
                               ~AXI_AWREADY_OUT & ~AXI_BVALID_OUT;
            if (wr_take) begin
                AXI_BVALID_OUT <= 1'b1;
                AXI_BRESP_OUT  <= mapped(AXI_AWADDR_IN) ? `ARPCT_RESP_OKAY : `ARPCT_RESP_SLVERR;
            end else if (AXI_BREADY_IN) begin
                AXI_BVALID_OUT <= 1'b0;
            end
            AXI_ARREADY_OUT <= AXI_ARVALID_IN & ~AXI_ARREADY_OUT & ~AXI_RVALID_OUT;
            if (rd_take) begin
                AXI_RVALID_OUT <= 1'b1;
                AXI_RDATA_OUT  <= {24'h000000, rdata_d};
                AXI_RRESP_OUT  <= rd_ok_d ? `ARPCT_RESP_OKAY : `ARPCT_RESP_SLVERR;
            end else if (AXI_RREADY_IN) begin
                AXI_RVALID_OUT <= 1'b0;
            end
        end
    end

endmodule // arpct_timer

`default_nettype wire

// ### rtl/arpct_defines.vh
`ifndef ARPCT_DEFINES_VH
`define ARPCT_DEFINES_VH

// ==========================================================================
// register indices (byte address = 4 * index)
`define ARPCT_IDX_DUTY3   8'h73
`define ARPCT_IDX_DUTY2   8'h74
`define ARPCT_IDX_DUTY1   8'h75
`define ARPCT_IDX_DUTY0   8'h76
`define ARPCT_IDX_PCTL    8'h77
`define ARPCT_IDX_TCSR    8'h78
`define ARPCT_IDX_CNT     8'h79
`define ARPCT_IDX_RELOAD  8'h7A
`define ARPCT_IDX_CCSR    8'h7B
`define ARPCT_IDX_CAP1    8'h7C
`define ARPCT_IDX_CAP2    8'h7D

// ==========================================================================
// timer_control_status fields
`define ARPCT_TCSR_EXT    7
`define ARPCT_TCSR_TAP_H  6
`define ARPCT_TCSR_TAP_L  4
`define ARPCT_TCSR_RUN    3
`define ARPCT_TCSR_FRL    2
`define ARPCT_TCSR_WIE    1
`define ARPCT_TCSR_WRAP   0
// writable bits of timer_control_status
`define ARPCT_TCSR_WMASK  8'hFA

// ==========================================================================
// pulse_channel_control and capture_control_status fields
`define ARPCT_PCTL_OE_H   7
`define ARPCT_PCTL_OE_L   4
`define ARPCT_PCTL_POL_H  3
`define ARPCT_PCTL_POL_L  0
`define ARPCT_CCSR_EDGE_H 5
`define ARPCT_CCSR_EDGE_L 4
`define ARPCT_CCSR_IE_H   3
`define ARPCT_CCSR_IE_L   2

// ==========================================================================
// reset values, counter limits, bus answers
`define ARPCT_RST8        8'h00
`define ARPCT_CNT_TOP     8'hFF
`define ARPCT_RESP_OKAY   2'h0
`define ARPCT_RESP_SLVERR 2'h2

`endif

// ### rtl/arpct_edge_sync.v
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// two-flop synchroniser with edge detect on the synchronised level
module arpct_edge_sync (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    // pin and edges
    input  wire       pin,
    output wire       rise,
    output wire       fall
);
    reg meta_q;
    reg sync_q;
    reg last_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else if (ce) begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // edges look only at the second and third stage
    assign rise = ce & sync_q & ~last_q;
    assign fall = ce & ~sync_q & last_q;

endmodule // arpct_edge_sync

`default_nettype wire

// ### test/arpct_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// checker: bus answers, pulse pins, halt behaviour, read-back fields
module arpct_checker (
    // clock and reset
    input wire logic        CLOCK_IN,
    input wire logic        RESET_IN,
    input wire logic        CE_IN,
    input wire logic        HALT_IN,
    // pins and requests
    input wire logic [3:0]  PULSE_OUTPUT_PIN_OUT,
    input wire logic [3:0]  PULSE_OUTPUT_OE_OUT,
    input wire logic        WRAP_IRQ_OUT,
    input wire logic [1:0]  CAPTURE_IRQ_OUT,
    input wire logic        WAKEUP_OUT,
    // register bus
    input wire logic        AXI_AWVALID_IN,
    input wire logic        AXI_AWREADY_OUT,
    input wire logic        AXI_WVALID_IN,
    input wire logic        AXI_WREADY_OUT,
    input wire logic [1:0]  AXI_BRESP_OUT,
    input wire logic        AXI_BVALID_OUT,
    input wire logic        AXI_BREADY_IN,
    input wire logic [11:0] AXI_ARADDR_IN,
    input wire logic        AXI_ARVALID_IN,
    input wire logic        AXI_ARREADY_OUT,
    input wire logic [31:0] AXI_RDATA_OUT,
    input wire logic [1:0]  AXI_RRESP_OUT,
    input wire logic        AXI_RVALID_OUT,
    input wire logic        AXI_RREADY_IN
);
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RESET_IN);

    // address of the read under way, so read data can be judged per register
    logic [11:0] raddr_q;
    always @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN)
            raddr_q <= 12'h000;
        else if (CE_IN && AXI_ARVALID_IN && AXI_ARREADY_OUT)
            raddr_q <= AXI_ARADDR_IN;
    end

    a_pin_off_disabled: assert property ((PULSE_OUTPUT_PIN_OUT & ~PULSE_OUTPUT_OE_OUT) == 4'h0)
        else $error("pulse pin high while its channel is disconnected");
    a_halt_holds_pwm: assert property (HALT_IN [*2] |=> $stable(PULSE_OUTPUT_PIN_OUT) && $stable(PULSE_OUTPUT_OE_OUT))
        else $error("pulse pins changed during halt");
    a_wake_needs_halt: assert property (WAKEUP_OUT |-> $past(HALT_IN))
        else $error("wakeup raised outside halt");
    a_write_taken: assert property (AXI_AWVALID_IN && AXI_WVALID_IN && !AXI_AWREADY_OUT && !AXI_BVALID_OUT && CE_IN
        |=> AXI_AWREADY_OUT && AXI_WREADY_OUT ##1 AXI_BVALID_OUT)
        else $error("write not taken and answered in time");
    a_read_taken: assert property (AXI_ARVALID_IN && !AXI_ARREADY_OUT && !AXI_RVALID_OUT && CE_IN
        |=> AXI_ARREADY_OUT ##1 AXI_RVALID_OUT)
        else $error("read not taken and answered in time");
    a_bresp_held: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN |=> AXI_BVALID_OUT && $stable(AXI_BRESP_OUT))
        else $error("write response dropped before taken");
    a_rdata_held: assert property (AXI_RVALID_OUT && !AXI_RREADY_IN
        |=> AXI_RVALID_OUT && $stable(AXI_RDATA_OUT) && $stable(AXI_RRESP_OUT))
        else $error("read data dropped before taken");
    a_reload_reads_zero: assert property (AXI_RVALID_OUT && raddr_q == 12'h1E0 |-> !AXI_RDATA_OUT[2])
        else $error("force reload bit read as one");
    a_wrap_irq_gated: assert property (AXI_RVALID_OUT && raddr_q == 12'h1E0 && WRAP_IRQ_OUT |-> AXI_RDATA_OUT[1])
        else $error("wrap request without its enable");
    a_capture_top_zero: assert property (AXI_RVALID_OUT && raddr_q == 12'h1EC |-> AXI_RDATA_OUT[7:6] == 2'h0)
        else $error("capture control top bits not zero");
    a_capture_irq_gated: assert property (AXI_RVALID_OUT && raddr_q == 12'h1EC
        |-> (CAPTURE_IRQ_OUT & ~(AXI_RDATA_OUT[3:2] & AXI_RDATA_OUT[1:0])) == 2'h0)
        else $error("capture request without flag and enable");

    a_ce_freezes_state: assert property (!CE_IN
        |=> $stable(PULSE_OUTPUT_PIN_OUT) && $stable(WRAP_IRQ_OUT) && $stable(AXI_BVALID_OUT))
        else $error("state moved while clock enable low");

    c_capture_irq: cover property ($rose(CAPTURE_IRQ_OUT[0]));
    c_wrap_irq: cover property ($rose(WRAP_IRQ_OUT));
    c_wakeup: cover property ($rose(WAKEUP_OUT));
endmodule // arpct_checker

bind arpct_timer arpct_checker arpct_checker_inst (
    .CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN), .CE_IN(CE_IN), .HALT_IN(HALT_IN),
    .PULSE_OUTPUT_PIN_OUT(PULSE_OUTPUT_PIN_OUT), .PULSE_OUTPUT_OE_OUT(PULSE_OUTPUT_OE_OUT),
    .WRAP_IRQ_OUT(WRAP_IRQ_OUT), .CAPTURE_IRQ_OUT(CAPTURE_IRQ_OUT), .WAKEUP_OUT(WAKEUP_OUT),
    .AXI_AWVALID_IN(AXI_AWVALID_IN), .AXI_AWREADY_OUT(AXI_AWREADY_OUT),
    .AXI_WVALID_IN(AXI_WVALID_IN), .AXI_WREADY_OUT(AXI_WREADY_OUT), .AXI_BRESP_OUT(AXI_BRESP_OUT),
    .AXI_BVALID_OUT(AXI_BVALID_OUT), .AXI_BREADY_IN(AXI_BREADY_IN), .AXI_ARADDR_IN(AXI_ARADDR_IN),
    .AXI_ARVALID_IN(AXI_ARVALID_IN), .AXI_ARREADY_OUT(AXI_ARREADY_OUT),
    .AXI_RDATA_OUT(AXI_RDATA_OUT), .AXI_RRESP_OUT(AXI_RRESP_OUT),
    .AXI_RVALID_OUT(AXI_RVALID_OUT), .AXI_RREADY_IN(AXI_RREADY_IN));

`default_nettype wire

// ### test/tb_autoreload_pwm_capture_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "arpct_defines.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; $display("FAIL %s expected %0h seen %0h", n, e, g); end end

// ==========================================================================
// randomised register, wrap period, pulse and capture checks
module tb_autoreload_pwm_capture_timer;
    localparam [11:0] ad_pctl = 12'h1DC, ad_tcsr = 12'h1E0, ad_cnt = 12'h1E4, ad_rld = 12'h1E8;
    localparam [11:0] ad_ccsr = 12'h1EC, ad_cap1 = 12'h1F0, ad_cap2 = 12'h1F4;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         halt = 1'b0;
    reg         ce = 1'b1;
    reg         ext = 1'b0;
    reg  [1:0]  cap = 2'h2;
    reg  [11:0] awaddr = 12'h000;
    reg  [11:0] araddr = 12'h000;
    reg  [31:0] wdata = 32'h0;
    reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire        awready, wready, bvalid, arready, rvalid, wirq, wake;
    wire [1:0]  bresp, rresp, cirq;
    wire [31:0] rdata;
    wire [3:0]  pin, oe;
    integer     errors = 0, comparisons = 0, seed = 29299, cyc = 0;
    integer     i, k, t, t0, t1;
    integer     hc [0:3];
    reg  [31:0] rv, duty, x;
    reg  [1:0]  rs;
    reg  [7:0]  r, v, d0;
    reg  [3:0]  oe_e, pol;

    arpct_timer arpct_timer_inst (
        .CLOCK_IN(clk), .RESET_IN(rst), .CE_IN(ce), .HALT_IN(halt), .EXT_CLK_IN(ext),
        .CAPTURE_INPUT_PIN_IN(cap), .PULSE_OUTPUT_PIN_OUT(pin), .PULSE_OUTPUT_OE_OUT(oe),
        .WRAP_IRQ_OUT(wirq), .CAPTURE_IRQ_OUT(cirq), .WAKEUP_OUT(wake),
        .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready),
        .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'hF), .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready),
        .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
        .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready),
        .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready));

    always #2.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    // ======================================================================
    // expectations
    function integer period(input [7:0] rl, input integer tp);
        period = (256 - rl) << tp;
    endfunction
    function integer highs(input [7:0] dc, input p, input o);
        highs = !o ? 0 : (p ? 255 - dc : dc + 1);
    endfunction

    // ======================================================================
    // bus cycles; a stuck answer counts as a mismatch
    task wr(input [11:0] a, input [7:0] dv);
        integer w;
        begin
            @(posedge clk);
            awaddr <= a; wdata <= {24'h0, dv}; awvalid <= 1'b1; wvalid <= 1'b1;
            w = 0;
            do begin
                @(posedge clk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                w++;
            end while (bvalid !== 1'b1 && w < 100);
            // ready follows the answer, so a held response is exercised
            bready <= 1'b1;
            @(posedge clk);
            rs = bresp;
            bready <= 1'b0;
            if (w >= 100) errors++;
        end
    endtask
    task rd(input [11:0] a);
        integer w;
        begin
            @(posedge clk);
            araddr <= a; arvalid <= 1'b1;
            w = 0;
            do begin
                @(posedge clk);
                if (arready) arvalid <= 1'b0;
                w++;
            end while (rvalid !== 1'b1 && w < 100);
            rready <= 1'b1;
            @(posedge clk);
            rv = rdata; rs = rresp;
            rready <= 1'b0;
            if (w >= 100) errors++;
        end
    endtask
    task chk_rd(input [11:0] a, input [7:0] e);
        begin
            rd(a);
            `CHK("read data", {`ARPCT_RESP_OKAY, 24'h0, e}, {rs, rv})
        end
    endtask
    task edge_in(input [1:0] pv);
        begin
            @(posedge clk);
            cap <= pv;
            repeat (8) @(posedge clk);
        end
    endtask
    task pulse;
        begin
            @(posedge clk); ext <= 1'b1;
            repeat (5) @(posedge clk); ext <= 1'b0;
            repeat (5) @(posedge clk);
        end
    endtask
    task wait_irq(output integer at);
        integer w;
        begin
            w = 0;
            do begin @(posedge clk); w++; end while (wirq !== 1'b1 && w < 5000);
            at = cyc;
            if (w >= 5000) errors++;
        end
    endtask
    task print_verdict;
        begin
            $display("errors %0d comparisons %0d", errors, comparisons);
            if (errors == 0 && comparisons > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    // longest leg is the wrap period sweep, well under this span
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        print_verdict;
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 11; i++) chk_rd(12'(12'h1CC + 4 * i), 8'h00);
        rd(12'h200);
        `CHK("unmapped read", {`ARPCT_RESP_SLVERR, 32'h0}, {rs, rv})
        wr(12'h1F8, 8'h55);
        `CHK("unmapped write", `ARPCT_RESP_SLVERR, rs)
        for (i = 0; i < 6; i++) begin
            x = $random(seed);
            wr(i < 5 ? 12'(12'h1CC + 4 * i) : ad_rld, x[7:0]);
            chk_rd(i < 5 ? 12'(12'h1CC + 4 * i) : ad_rld, x[7:0]);
        end
        // force reload while stopped: counter takes reload, bit reads zero
        wr(ad_rld, 8'hA5); wr(ad_tcsr, 8'hF6);
        chk_rd(ad_tcsr, 8'hF2);
        chk_rd(ad_cnt, 8'hA5);
        wr(ad_cap1, 8'h33);
        chk_rd(ad_cap1, 8'h00);
        // wrap period for every tap, rise to rise of the request
        for (t = 0; t < 8; t++) begin
            x = $random(seed);
            r = 8'hE0 | x[3:0];
            wr(ad_rld, r); wr(ad_cnt, r); wr(ad_tcsr, {1'b0, t[2:0], 4'hA});
            rd(ad_tcsr); repeat (2) @(posedge clk); wait_irq(t0);
            chk_rd(ad_tcsr, {1'b0, t[2:0], 4'hB});
            repeat (2) @(posedge clk); wait_irq(t1);
            `CHK("wrap period", period(r, t), t1 - t0)
        end
        wr(ad_tcsr, 8'h08); repeat (300) @(posedge clk);
        `CHK("masked wrap request", 1'b0, wirq)
        chk_rd(ad_tcsr, 8'h09);
        // duty, enable and polarity; last round flips polarity only
        wr(ad_rld, 8'h00);
        for (k = 0; k < 3; k++) begin
            if (k < 2) begin
                duty = $random(seed); x = $random(seed); oe_e = x[7:4]; pol = x[3:0];
                for (i = 0; i < 4; i++) wr(12'(12'h1D8 - 4 * i), duty[8 * i +: 8]);
            end else
                pol = ~pol;
            wr(ad_pctl, {oe_e, pol});
            // clock enable low must freeze the running counter and pins
            if (k < 2) begin ce <= 1'b0; repeat (20) @(posedge clk); ce <= 1'b1; end
            repeat (k < 2 ? 300 : 2) @(posedge clk);
            `CHK("pin enables", oe_e, oe)
            for (i = 0; i < 4; i++) hc[i] = 0;
            repeat (256) begin
                @(posedge clk);
                for (i = 0; i < 4; i++) hc[i] += pin[i];
            end
            for (i = 0; i < 4; i++) `CHK("high cycles", highs(duty[8 * i +: 8], pol[i], oe_e[i]), hc[i])
        end
        // captures on a stopped counter
        wr(ad_tcsr, 8'h00); d0 = $random(seed); wr(ad_cnt, d0); wr(ad_ccsr, 8'h1C);
        edge_in(2'h1);
        `CHK("capture requests", 2'h3, cirq)
        chk_rd(ad_ccsr, 8'h1F);
        v = $random(seed); wr(ad_cnt, v); edge_in(2'h2); edge_in(2'h1);
        chk_rd(ad_cap1, d0);
        repeat (2) @(posedge clk);
        `CHK("capture requests", 2'h2, cirq)
        chk_rd(ad_cap2, d0);
        chk_rd(ad_ccsr, 8'h1C);
        edge_in(2'h2); wr(ad_cnt, d0); edge_in(2'h1);
        chk_rd(ad_cap1, d0);
        chk_rd(ad_cap2, d0);
        wr(ad_ccsr, 8'h10); edge_in(2'h0); edge_in(2'h1);
        `CHK("disabled capture request", 2'h0, cirq)
        chk_rd(ad_ccsr, 8'h11);
        chk_rd(ad_cap1, d0);
        // halt: external events still counted, writes dropped, wake-up
        // stale wrap flag from the pulse legs must be cleared first
        chk_rd(ad_tcsr, 8'h01);
        wr(ad_rld, 8'hFC); wr(ad_cnt, 8'hFC); wr(ad_ccsr, 8'h14); wr(ad_tcsr, 8'h8A);
        @(posedge clk); halt <= 1'b1;
        wr(ad_rld, 8'h11);
        repeat (3) pulse;
        `CHK("wrap before last event", 1'b0, wirq)
        pulse; repeat (4) @(posedge clk);
        `CHK("wrap after events", 1'b1, wirq)
        `CHK("wake on wrap", 1'b1, wake)
        chk_rd(ad_tcsr, 8'h8B);
        chk_rd(ad_rld, 8'hFC);
        edge_in(2'h0); edge_in(2'h1);
        `CHK("capture request in halt", 2'h1, cirq)
        `CHK("wake on capture", 1'b1, wake)
        chk_rd(ad_cap1, 8'hFC);
        halt <= 1'b0;
        print_verdict;
    end
endmodule // tb_autoreload_pwm_capture_timer

`default_nettype wire
